// >>> core/fpet_pkg.sv
// package: constants and types for the flash program/erase timer
// Behaviour
// RQ1 - setup = Tclk*(prescale+1)*(setup_count+1); software keeps it >= 5 us
// RQ2 - transition = Tclk*(prescale+1)*(transition_count+1); at least 10 us
// RQ3 - program pulse = Tclk*(prescale+1)*8*(count+1); within 20..40 us
// RQ4 - page erase pulse = Tclk*(prescale+1)*4096*(count+1); at least 20 ms
// RQ5 - module erase pulse = Tclk*(prescale+1)*4096*(count+1); >= 200 ms
// RQ6 - strobe hold after program/page erase = (prescale+1)*(hold+1); >= 5 us
// RQ7 - strobe hold after module erase = (prescale+1)*8*(count+1); >= 100 us
// RQ8 - recovery = Tclk*(prescale+1)*(recovery_count+1); at least 1 us
// RQ9 - separate register sets per array; each array uses only its own
// RQ10 - controller limits cumulative program exposure: 8 ms / 4 ms per row; this timer keeps no exposure tally
// RQ11 - order: op, setup, strobe, transition, pulse, hold, release, recover
package fpet_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned PRESCALE_W = 8;
  localparam int unsigned COUNT_W = 8;
  localparam int unsigned PROG_MULT = 8;
  localparam int unsigned ERASE_MULT = 4096;
  localparam int unsigned MEND_MULT = 8;
  localparam int unsigned MULT_W = 12;

  typedef enum logic [1:0] {
    FPET_OP_PROGRAM,
    FPET_OP_PAGE_ERASE,
    FPET_OP_MODULE_ERASE
  } fpet_op_t;

  // one array's timing register set
  typedef struct packed {
    logic [PRESCALE_W-1:0] timing_prescale_value;
    logic [COUNT_W-1:0] setup_count;
    logic [COUNT_W-1:0] transition_count;
    logic [COUNT_W-1:0] program_pulse_count;
    logic [COUNT_W-1:0] page_erase_count;
    logic [COUNT_W-1:0] module_erase_count;
    logic [COUNT_W-1:0] hold_count;
    logic [COUNT_W-1:0] module_hold_count;
    logic [COUNT_W-1:0] recovery_count;
  } fpet_timing_t;
endpackage : fpet_pkg

// >>> core/fpet_tick_if.sv
// interface: prescaler tick between timer and its divider
`timescale 1ns/1ps
interface fpet_tick_if;
  import fpet_pkg::*;
  logic run;
  logic [PRESCALE_W-1:0] div;
  logic tick;
  modport ctrl (output run, output div, input tick);
  modport presc (input run, input div, output tick);
endinterface : fpet_tick_if

// >>> core/fpet_prescaler.sv
// module: prescaler giving one tick every (div+1) clocks while running
`timescale 1ns/1ps
module fpet_prescaler (
  input wire logic core_clk_i, // system clock
  input wire logic rst_n_i, // sync reset, active low
  fpet_tick_if.presc tk // tick port
);
  import fpet_pkg::*;
  logic [PRESCALE_W-1:0] cnt;
  logic [PRESCALE_W-1:0] next_cnt;
  logic next_tick;

  // restart from zero whenever idle so the first tick is a full period
  always_comb begin
    next_cnt = '0;
    next_tick = 1'b0;
    if (tk.run) begin
      if (cnt == tk.div) begin // see RQ1
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // tick is combinational on the wrap; a registered tick would add a cycle
  assign tk.tick = next_tick;
endmodule : fpet_prescaler

// >>> core/fpet_flash_program_erase_timer.sv
// module: sequencer timing flash program and erase phases
`timescale 1ns/1ps
module fpet_flash_program_erase_timer (
  input wire logic core_clk_i, // system clock, 250 MHz
  input wire logic rst_n_i, // sync reset, active low
  input wire logic start_i, // one-cycle start request
  input wire fpet_pkg::fpet_op_t op_i, // operation kind
  input wire logic data_array_i, // 1 selects data-flash array
  input wire fpet_pkg::fpet_timing_t prog_timing_i, // prog-flash set
  input wire fpet_pkg::fpet_timing_t data_timing_i, // data-flash set
  output logic program_o, // program line to array
  output logic erase_o, // erase line to array
  output logic module_erase_o, // whole-module erase select
  output logic storage_strobe_o, // storage strobe
  output logic pulse_o, // high-voltage pulse active
  output logic data_array_o, // array under operation
  output logic busy_o, // sequence in progress
  output logic done_o // one-cycle pulse at end of recovery
);
  import fpet_pkg::*;

  typedef enum logic [2:0] {
    FPET_IDLE,
    FPET_SETUP,
    FPET_TRAN,
    FPET_PULSE,
    FPET_HOLD,
    FPET_RECOVER
  } fpet_state_t;

  fpet_tick_if tk ();

  fpet_state_t state, next_state;
  fpet_op_t op, next_op;
  logic sel, next_sel;
  fpet_timing_t tm, next_tm;
  logic [COUNT_W-1:0] cnt, next_cnt;
  logic [MULT_W-1:0] sub, next_sub;
  logic program_q, next_program;
  logic erase_q, next_erase;
  logic strobe_q, next_strobe;
  logic pulse_q, next_pulse;
  logic done_q, next_done;
  logic busy_q, next_busy;
  logic module_q, next_module;

  fpet_prescaler u_presc (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tk(tk)
  );

  // inner multiplier limit minus one for a phase
  function automatic logic [MULT_W-1:0] sub_max(
    input fpet_state_t st,
    input fpet_op_t o
  );
    logic [MULT_W-1:0] r;
    r = '0;
    case (st)
      FPET_PULSE: begin
        if (o == FPET_OP_PROGRAM) begin
          r = MULT_W'(PROG_MULT - 1); // see RQ3
        end else begin
          r = MULT_W'(ERASE_MULT - 1); // see RQ4 see RQ5
        end
      end
      FPET_HOLD: begin
        if (o == FPET_OP_MODULE_ERASE) begin
          r = MULT_W'(MEND_MULT - 1); // see RQ7
        end
      end
      default: r = '0;
    endcase
    return r;
  endfunction : sub_max

  // outer count for a phase, from the latched register set
  function automatic logic [COUNT_W-1:0] phase_count(
    input fpet_state_t st,
    input fpet_op_t o,
    input fpet_timing_t t
  );
    logic [COUNT_W-1:0] r;
    r = '0;
    case (st)
      FPET_SETUP: r = t.setup_count; // see RQ1
      FPET_TRAN: r = t.transition_count; // see RQ2
      FPET_PULSE: begin
        case (o)
          FPET_OP_PROGRAM: r = t.program_pulse_count; // see RQ3
          FPET_OP_PAGE_ERASE: r = t.page_erase_count; // see RQ4
          default: r = t.module_erase_count; // see RQ5
        endcase
      end
      FPET_HOLD: begin
        if (o == FPET_OP_MODULE_ERASE) begin
          r = t.module_hold_count; // see RQ7
        end else begin
          r = t.hold_count; // see RQ6
        end
      end
      FPET_RECOVER: r = t.recovery_count; // see RQ8
      default: r = '0;
    endcase
    return r;
  endfunction : phase_count

  assign tk.run = (state != FPET_IDLE);
  assign tk.div = tm.timing_prescale_value;

  // phase sequencing; each phase lasts (div+1)*mult*(count+1) clocks
  always_comb begin
    logic last;
    last = 1'b0;
    next_state = state;
    next_op = op;
    next_sel = sel;
    next_tm = tm;
    next_cnt = cnt;
    next_sub = sub;
    next_program = program_q;
    next_erase = erase_q;
    next_strobe = strobe_q;
    next_pulse = pulse_q;
    next_done = 1'b0;
    case (state)
      FPET_IDLE: begin
        if (start_i) begin
          next_op = op_i;
          next_sel = data_array_i;
          // latch only the chosen array's set
          next_tm = data_array_i ? data_timing_i : prog_timing_i; // see RQ9
          next_program = (op_i == FPET_OP_PROGRAM); // see RQ11
          next_erase = (op_i != FPET_OP_PROGRAM);
          next_cnt = '0;
          next_sub = '0;
          next_state = FPET_SETUP;
        end
      end
      default: begin
        if (tk.tick) begin
          if (sub != sub_max(state, op)) begin
            next_sub = sub + 1'b1;
          end else begin
            next_sub = '0;
            if (cnt != phase_count(state, op, tm)) begin
              next_cnt = cnt + 1'b1;
            end else begin
              next_cnt = '0;
              last = 1'b1;
            end
          end
        end
        if (last) begin
          case (state)
            FPET_SETUP: begin
              next_strobe = 1'b1; // see RQ11
              next_state = FPET_TRAN;
            end
            FPET_TRAN: begin
              next_pulse = 1'b1;
              next_state = FPET_PULSE;
            end
            FPET_PULSE: begin
              // program/erase drop with the pulse, strobe stays
              next_pulse = 1'b0; // see RQ11
              next_program = 1'b0;
              next_erase = 1'b0;
              next_state = FPET_HOLD;
            end
            FPET_HOLD: begin
              next_strobe = 1'b0; // see RQ11
              next_state = FPET_RECOVER;
            end
            default: begin
              next_done = 1'b1; // see RQ8
              next_state = FPET_IDLE;
            end
          endcase
        end
      end
    endcase
    // registered copies so these outputs come straight from flops
    next_busy = (next_state != FPET_IDLE);
    next_module = next_erase && (next_op == FPET_OP_MODULE_ERASE); // see RQ5
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state <= FPET_IDLE;
      op <= FPET_OP_PROGRAM;
      sel <= 1'b0;
      tm <= '0;
      cnt <= '0;
      sub <= '0;
      program_q <= 1'b0;
      erase_q <= 1'b0;
      strobe_q <= 1'b0;
      pulse_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      module_q <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      sel <= next_sel;
      tm <= next_tm;
      cnt <= next_cnt;
      sub <= next_sub;
      program_q <= next_program;
      erase_q <= next_erase;
      strobe_q <= next_strobe;
      pulse_q <= next_pulse;
      done_q <= next_done;
      busy_q <= next_busy;
      module_q <= next_module;
    end
  end

  // outputs straight from flip-flops
  assign program_o = program_q;
  assign erase_o = erase_q;
  assign module_erase_o = module_q;
  assign storage_strobe_o = strobe_q;
  assign pulse_o = pulse_q;
  assign data_array_o = sel;
  assign busy_o = busy_q;
  assign done_o = done_q;
endmodule : fpet_flash_program_erase_timer

// >>> bench/fpet_sva.sv
// checker: phase order and handshake properties of the sequencer
`timescale 1ns/1ps
module fpet_sva (
  input wire logic core_clk_i, // clock
  input wire logic rst_n_i, // reset, active low
  input wire logic start_i, // start request
  input wire logic program_o, // program line
  input wire logic erase_o, // erase line
  input wire logic module_erase_o, // module erase select
  input wire logic storage_strobe_o, // strobe
  input wire logic pulse_o, // pulse phase
  input wire logic busy_o, // busy
  input wire logic done_o // done pulse
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // phase sequencing, one property per hazard
  start_resp_a: assert property (
    start_i && !busy_o |=> busy_o && (program_o || erase_o))
    else $error("start not answered");
  strobe_rise_a: assert property (
    $rose(storage_strobe_o) |-> (program_o || erase_o) && !pulse_o)
    else $error("strobe early");
  pulse_strobe_a: assert property (
    pulse_o |-> storage_strobe_o && (program_o ^ erase_o))
    else $error("pulse outside strobe");
  pulse_min_a: assert property (
    $rose(pulse_o) |-> pulse_o[*8])
    else $error("pulse too short");
  pulse_end_a: assert property (
    $fell(pulse_o) |-> storage_strobe_o && !program_o && !erase_o)
    else $error("bad pulse end");
  strobe_end_a: assert property (
    $fell(storage_strobe_o) |-> busy_o && !pulse_o)
    else $error("strobe end out of order");
  done_once_a: assert property (
    done_o |=> !done_o)
    else $error("done too long");
  done_idle_a: assert property (
    done_o |-> !busy_o && !storage_strobe_o && !program_o && !erase_o)
    else $error("done while active");
  module_sel_a: assert property (
    module_erase_o |-> erase_o)
    else $error("module select without erase");
endmodule : fpet_sva

// >>> bench/fpet_flash_program_erase_timer_tb.sv
// testbench: random and corner timing runs of the sequencer
`timescale 1ns/1ps
module fpet_flash_program_erase_timer_tb;
  import fpet_pkg::*;
  logic core_clk_i, rst_n_i, start_i, data_array_i;
  fpet_op_t op_i;
  fpet_timing_t prog_timing_i, data_timing_i;
  logic program_o, erase_o, module_erase_o, storage_strobe_o;
  logic pulse_o, data_array_o, busy_o, done_o;
  int fail_count, compares, seed;
  fpet_flash_program_erase_timer i_dut (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i),
    .data_array_i(data_array_i), .prog_timing_i(prog_timing_i),
    .data_timing_i(data_timing_i), .program_o(program_o),
    .erase_o(erase_o), .module_erase_o(module_erase_o),
    .storage_strobe_o(storage_strobe_o), .pulse_o(pulse_o),
    .data_array_o(data_array_o), .busy_o(busy_o), .done_o(done_o));
  // 250 MHz system clock
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // compares for interval lengths and output levels
  task automatic chk_n(input int got, input int exp);
    compares++;
    if (got != exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_n
  task automatic chk_b(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_b
  // phase edge events in sequence order
  function automatic logic hit(input int s);
    case (s)
      0: return program_o | erase_o;
      1: return storage_strobe_o;
      2: return pulse_o;
      3: return !pulse_o;
      4: return !storage_strobe_o;
      default: return done_o;
    endcase
  endfunction : hit
  // counts cycles to the next event; a refused start and new timing
  // are thrown in while busy, and must leave the running op untouched
  task automatic wait_for(input int s, output int n);
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
      // only touch start when it changes, never twice in one step
      if (n == 1 && (s == 0 || s == 2 || s == 3)) start_i = (s == 2);
      if (s == 2 && n == 1) begin
        op_i = FPET_OP_MODULE_ERASE;
        prog_timing_i = ~prog_timing_i;
        data_timing_i = ~data_timing_i;
      end
    end while (hit(s) !== 1'b1 && n < 40000);
  endtask : wait_for
  // one sequence; mode 1 all counts zero, mode 2 counts at maximum
  task automatic run_op(input fpet_op_t op, input logic arr, input int mode);
    fpet_timing_t t;
    int p, e[6];
    // small counts: one short pulse per row, far under the cap
    for (int i = 0; i < 9; i++) t[i*8+:8] = 8'($random(seed)) & 8'h03;
    t.page_erase_count = 8'h00;
    t.module_erase_count = 8'h00;
    if (op != FPET_OP_PROGRAM) t.timing_prescale_value &= 8'h01;
    if (mode == 1) t = '0;
    if (mode == 2) t = {8'h00, {64{1'b1}}};
    // other array gets the inverted set: far longer counts in modes 0 and 1, equal phase lengths in mode 2
    prog_timing_i = arr ? ~t : t;
    data_timing_i = arr ? t : ~t;
    op_i = op;
    data_array_i = arr;
    start_i = 1'b1;
    p = t.timing_prescale_value + 1;
    for (int k = 0; k < 6; k++) begin
      wait_for(k, e[k]);
      if (k == 2) begin
        chk_b(program_o, op == FPET_OP_PROGRAM);
        chk_b(erase_o, op != FPET_OP_PROGRAM);
        chk_b(module_erase_o, op == FPET_OP_MODULE_ERASE);
        chk_b(data_array_o, arr);
      end
    end
    chk_n(e[0], 1);
    chk_n(e[1], p * (t.setup_count + 1));
    chk_n(e[2], p * (t.transition_count + 1));
    chk_n(e[3], op == FPET_OP_PROGRAM ?
      p * 8 * (t.program_pulse_count + 1) :
      p * 4096 * ((op == FPET_OP_PAGE_ERASE ? t.page_erase_count :
      t.module_erase_count) + 1));
    chk_n(e[4], p * (op == FPET_OP_MODULE_ERASE ?
      8 * (t.module_hold_count + 1) : t.hold_count + 1));
    chk_n(e[5], p * (t.recovery_count + 1));
    $display("test op=%0d arr=%0d mode=%0d done", op, arr, mode);
  endtask : run_op
  task automatic tally_and_finish;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // main sequence: corners, every op on both arrays, mid-run reset
  initial begin
    seed = 32'h7cfc;
    fail_count = 0;
    compares = 0;
    rst_n_i = 1'b0;
    start_i = 1'b0;
    op_i = FPET_OP_PROGRAM;
    data_array_i = 1'b0;
    prog_timing_i = '0;
    data_timing_i = '0;
    repeat (3) @(negedge core_clk_i);
    rst_n_i = 1;
    chk_b(busy_o | storage_strobe_o | pulse_o | done_o, 1'b0);
    run_op(FPET_OP_PROGRAM, 1'b0, 1);
    run_op(FPET_OP_PROGRAM, 1'b1, 2);
    for (int i = 0; i < 8; i++) run_op(fpet_op_t'(i % 3), i[0], 0);
    start_i = 1;
    @(negedge core_clk_i);
    start_i = 0;
    repeat (5) @(negedge core_clk_i);
    rst_n_i = 0;
    @(negedge core_clk_i);
    chk_b(busy_o | program_o | storage_strobe_o, 1'b0);
    rst_n_i = 1'b1;
    // a full module erase right after the mid-run reset is released
    run_op(FPET_OP_MODULE_ERASE, 1'b0, 1);
    tally_and_finish();
  end
  // hang guard: the full run needs well under this span
  initial begin
    #400us;
    fail_count++;
    tally_and_finish();
  end
endmodule : fpet_flash_program_erase_timer_tb
bind fpet_flash_program_erase_timer fpet_sva i_sva (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .start_i(start_i), .program_o(program_o),
  .erase_o(erase_o), .module_erase_o(module_erase_o),
  .storage_strobe_o(storage_strobe_o), .pulse_o(pulse_o),
  .busy_o(busy_o), .done_o(done_o));
